// >>> design/msc_top.sv
// Mode pin decode, mode readback, system control register and power states.
// Assumes mode and NMI pins are asynchronous; other inputs share CORE_CLK_I.
//
// The implementer's own choice: the plain strobed port.

module msc_top #(
	parameter int WAIT_SEL0 = msc_pkg::MSC_WAIT_SEL0,
	parameter int WAIT_SEL1 = msc_pkg::MSC_WAIT_SEL1,
	parameter int WAIT_SEL2 = msc_pkg::MSC_WAIT_SEL2,
	parameter int WAIT_SEL3 = msc_pkg::MSC_WAIT_SEL3,
	parameter int WAIT_SEL4 = msc_pkg::MSC_WAIT_SEL4,
	parameter int WAIT_SEL5 = msc_pkg::MSC_WAIT_SEL5
) (
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_B_I,
	// Register port
	input wire logic [15:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [7:0] REG_RDATA_O,
	// Mode strap pins
	input wire logic MODE_PIN_HIGH_I,
	input wire logic MODE_PIN_MID_I,
	input wire logic MODE_PIN_LOW_I,
	// Decoded operating mode
	output logic MODE_VALID_O,
	output logic EXPANDED_O,
	output logic ROM_EN_O,
	output logic SPACE_16M_O,
	output logic SINGLE_CHIP_O,
	output logic BUS_8BIT_O,
	// Power-down control
	input wire logic SLEEP_I,
	input wire logic IRQ_I,
	input wire logic EXT_IRQ_I,
	output logic SLEEP_O,
	output logic STANDBY_O,
	output logic SETTLING_O,
	// Interrupt handling
	input wire logic NMI_PIN_I,
	input wire logic EXC_ENTRY_I,
	output logic NMI_REQ_O,
	output logic USER_FLAG_ENABLE_O,
	output logic SET_INT_MASK_O,
	output logic SET_USER_MASK_O,
	// On-chip RAM gating
	input wire logic RAM_RD_I,
	input wire logic RAM_WR_I,
	input wire logic [7:0] RAM_RDATA_I,
	output logic [7:0] RAM_RDATA_O,
	output logic RAM_WR_EN_O,
	output logic RAM_EN_O,
	output logic RAM_EXTERNAL_O
);
	import msc_pkg::*;

	typedef struct packed {
		logic [2:0] mode_meta;
		logic [2:0] mode_sync;
		logic nmi_meta;
		logic nmi_sync;
		logic nmi_prev;
		logic [7:0] rdata;
		logic standby_select;
		logic [2:0] sts;
		logic ue;
		logic nonmaskable_edge_select;
		logic onchip_ram_enable;
		msc_pwr_t pwr;
		logic settle_start;
		logic mode_valid;
		logic expanded;
		logic rom_en;
		logic space16;
		logic single;
		logic sleep;
		logic standby;
		logic settling;
		logic nmi_req;
		logic set_imask;
		logic set_umask;
		logic ram_blk;
		logic ram_ext;
		logic [7:0] ram_rdata;
		logic ram_wr_en;
	} msc_state_t;

	msc_state_t s_r;
	msc_state_t s_nxt;
	logic settle_done;
	logic nmi_edge;
	logic [4:0] dec;

	// Returns {valid, expanded, rom_en, space16, single_chip}
	function automatic logic [4:0] msc_decode(input logic [2:0] pins);
		logic [4:0] r;
		r = 5'h00;
		case (pins)
			MSC_MODE1: r = 5'b11000;
			MSC_MODE3: r = 5'b11010;
			MSC_MODE5: r = 5'b11100;
			MSC_MODE6: r = 5'b11110;
			MSC_MODE7: r = 5'b10101;
			default: r = 5'h00;
		endcase
		return r;
	endfunction

	function automatic logic [7:0] msc_sys_value(input msc_state_t st);
		logic [7:0] v;
		v = 8'h00;
		v[MSC_STANDBY_SELECT_BIT] = st.standby_select;
		v[MSC_STS_HI:MSC_STS_LO] = st.sts;
		v[MSC_UE_BIT] = st.ue;
		v[MSC_NONMASKABLE_EDGE_SELECT_BIT] = st.nonmaskable_edge_select;
		v[MSC_RSV_BIT] = 1'b1;
		v[MSC_ONCHIP_RAM_ENABLE_BIT] = st.onchip_ram_enable;
		return v;
	endfunction

	// Illegal 11x selections fall back to the longest wait, the safe side
	function automatic logic [MSC_WAIT_W-1:0] msc_wait(input logic [2:0] sel);
		logic [MSC_WAIT_W-1:0] w;
		w = MSC_WAIT_W'(WAIT_SEL4);
		case (sel)
			3'h0: w = MSC_WAIT_W'(WAIT_SEL0);
			3'h1: w = MSC_WAIT_W'(WAIT_SEL1);
			3'h2: w = MSC_WAIT_W'(WAIT_SEL2);
			3'h3: w = MSC_WAIT_W'(WAIT_SEL3);
			3'h4: w = MSC_WAIT_W'(WAIT_SEL4);
			3'h5: w = MSC_WAIT_W'(WAIT_SEL5);
			default: w = MSC_WAIT_W'(WAIT_SEL4);
		endcase
		return w;
	endfunction

	assign dec = msc_decode(s_r.mode_sync);
	assign nmi_edge = s_r.nonmaskable_edge_select ? (s_r.nmi_sync & ~s_r.nmi_prev)
		: (~s_r.nmi_sync & s_r.nmi_prev);

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.mode_meta = {MODE_PIN_HIGH_I, MODE_PIN_MID_I, MODE_PIN_LOW_I};
		s_nxt.mode_sync = s_r.mode_meta;
		s_nxt.nmi_meta = NMI_PIN_I;
		s_nxt.nmi_sync = s_r.nmi_meta;
		s_nxt.nmi_prev = s_r.nmi_sync;
		// Straps are assumed static, so decode is refreshed every cycle
		s_nxt.mode_valid = dec[4];
		s_nxt.expanded = dec[3];
		s_nxt.rom_en = dec[2];
		s_nxt.space16 = dec[1];
		s_nxt.single = dec[0];
		// Read data stands in the cycle after the strobe only
		s_nxt.rdata = 8'h00;
		if (REG_RD_I)
		begin
			if (REG_ADDR_I == MSC_READBACK_OFS)
			begin
				// Pin levels are captured at the read itself
				s_nxt.rdata = MSC_READBACK_FIXED
					| {5'h00, s_r.mode_sync};
			end
			else if (REG_ADDR_I == MSC_SYS_CTRL_OFS)
			begin
				s_nxt.rdata = msc_sys_value(s_r);
			end
		end
		// The readback address has no write path at all
		if (REG_WR_I && REG_ADDR_I == MSC_SYS_CTRL_OFS)
		begin
			s_nxt.standby_select = REG_WDATA_I[MSC_STANDBY_SELECT_BIT];
			s_nxt.sts = REG_WDATA_I[MSC_STS_HI:MSC_STS_LO];
			s_nxt.ue = REG_WDATA_I[MSC_UE_BIT];
			s_nxt.nonmaskable_edge_select = REG_WDATA_I[MSC_NONMASKABLE_EDGE_SELECT_BIT];
			s_nxt.onchip_ram_enable = REG_WDATA_I[MSC_ONCHIP_RAM_ENABLE_BIT];
		end
		// Taken from the new enable so gating moves with RAM_EN_O
		s_nxt.ram_ext = dec[3] & ~s_nxt.onchip_ram_enable;
		s_nxt.ram_blk = dec[0] & ~s_nxt.onchip_ram_enable;
		s_nxt.nmi_req = nmi_edge;
		s_nxt.set_imask = EXC_ENTRY_I;
		s_nxt.set_umask = EXC_ENTRY_I & ~s_r.ue;
		// Power states; standby never touches the control fields
		s_nxt.settle_start = 1'b0;
		case (s_r.pwr)
			MSC_PWR_RUN:
			begin
				if (SLEEP_I)
					s_nxt.pwr = s_r.standby_select ? MSC_PWR_STANDBY
						: MSC_PWR_SLEEP;
			end
			MSC_PWR_SLEEP:
			begin
				if (IRQ_I || nmi_edge)
					s_nxt.pwr = MSC_PWR_RUN;
			end
			MSC_PWR_STANDBY:
			begin
				if (EXT_IRQ_I || nmi_edge)
				begin
					s_nxt.pwr = MSC_PWR_SETTLE;
					s_nxt.settle_start = 1'b1;
				end
			end
			MSC_PWR_SETTLE:
			begin
				if (settle_done)
					s_nxt.pwr = MSC_PWR_RUN;
			end
			default: s_nxt.pwr = MSC_PWR_RUN;
		endcase
		s_nxt.sleep = s_nxt.pwr == MSC_PWR_SLEEP;
		s_nxt.standby = s_nxt.pwr == MSC_PWR_STANDBY;
		s_nxt.settling = s_nxt.pwr == MSC_PWR_SETTLE;
		// Blocked RAM reads answer 0xff and writes never reach the array
		s_nxt.ram_rdata = 8'h00;
		if (RAM_RD_I)
			s_nxt.ram_rdata = s_r.ram_blk ? MSC_RAM_BLOCKED_DATA
				: RAM_RDATA_I;
		s_nxt.ram_wr_en = RAM_WR_I & ~s_r.ram_blk;
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (!RST_B_I)
		begin
			s_r <= '0;
			s_r.ue <= MSC_SYS_CTRL_RST[MSC_UE_BIT];
			s_r.onchip_ram_enable <= MSC_SYS_CTRL_RST[MSC_ONCHIP_RAM_ENABLE_BIT];
			s_r.standby_select <= MSC_SYS_CTRL_RST[MSC_STANDBY_SELECT_BIT];
			s_r.nonmaskable_edge_select <= MSC_SYS_CTRL_RST[MSC_NONMASKABLE_EDGE_SELECT_BIT];
			s_r.sts <= MSC_SYS_CTRL_RST[MSC_STS_HI:MSC_STS_LO];
			s_r.pwr <= MSC_PWR_RUN;
			// NMI idles high; a low reset value would fake a rising edge
			s_r.nmi_meta <= 1'b1;
			s_r.nmi_sync <= 1'b1;
			s_r.nmi_prev <= 1'b1;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	msc_settle_timer #(
		.CNT_W(MSC_WAIT_W)
	) u_settle (
		.clk_i(CORE_CLK_I),
		.rst_b_i(RST_B_I),
		.start_i(s_r.settle_start),
		.count_i(msc_wait(s_r.sts)),
		.done_o(settle_done)
	);

	assign REG_RDATA_O = s_r.rdata;
	assign MODE_VALID_O = s_r.mode_valid;
	assign EXPANDED_O = s_r.expanded;
	assign ROM_EN_O = s_r.rom_en;
	assign SPACE_16M_O = s_r.space16;
	assign SINGLE_CHIP_O = s_r.single;
	// Bus controller widens later; this block only fixes the reset width
	assign BUS_8BIT_O = s_r.expanded;
	assign SLEEP_O = s_r.sleep;
	assign STANDBY_O = s_r.standby;
	assign SETTLING_O = s_r.settling;
	assign NMI_REQ_O = s_r.nmi_req;
	assign USER_FLAG_ENABLE_O = s_r.ue;
	assign SET_INT_MASK_O = s_r.set_imask;
	assign SET_USER_MASK_O = s_r.set_umask;
	assign RAM_RDATA_O = s_r.ram_rdata;
	assign RAM_WR_EN_O = s_r.ram_wr_en;
	assign RAM_EN_O = s_r.onchip_ram_enable;
	assign RAM_EXTERNAL_O = s_r.ram_ext;

	property p_readback_pins;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		REG_RD_I && REG_ADDR_I == MSC_READBACK_OFS
		|=> REG_RDATA_O[2:0] == $past(s_r.mode_sync);
	endproperty
	a_readback_pins: assert property (p_readback_pins)
		else $error("readback pins differ from sampled straps");

	property p_readback_fixed;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		REG_RD_I && REG_ADDR_I == MSC_READBACK_OFS
		|=> REG_RDATA_O[7:3] == 5'h18;
	endproperty
	a_readback_fixed: assert property (p_readback_fixed)
		else $error("readback fixed bits wrong");

	property p_readback_nowrite;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		REG_WR_I && REG_ADDR_I == MSC_READBACK_OFS
		|=> $stable(msc_sys_value(s_r));
	endproperty
	a_readback_nowrite: assert property (p_readback_nowrite)
		else $error("write to readback changed state");

	property p_reserved_one;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		REG_RD_I && REG_ADDR_I == MSC_SYS_CTRL_OFS |=> REG_RDATA_O[1];
	endproperty
	a_reserved_one: assert property (p_reserved_one)
		else $error("reserved control bit read zero");

	property p_sleep_choice;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		s_r.pwr == MSC_PWR_RUN && SLEEP_I
		|=> (STANDBY_O == $past(s_r.standby_select)) && (SLEEP_O != $past(s_r.standby_select));
	endproperty
	a_sleep_choice: assert property (p_sleep_choice)
		else $error("sleep entered wrong power state");

	property p_standby_select_sticky;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		s_r.standby_select && !(REG_WR_I && REG_ADDR_I == MSC_SYS_CTRL_OFS)
		|=> s_r.standby_select;
	endproperty
	a_standby_select_sticky: assert property (p_standby_select_sticky)
		else $error("standby select cleared without a write");

	property p_nmi_rise;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		s_r.nonmaskable_edge_select && s_r.nmi_sync && !s_r.nmi_prev |=> NMI_REQ_O;
	endproperty
	a_nmi_rise: assert property (p_nmi_rise)
		else $error("rising NMI edge not requested");

	property p_ram_blocked;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		RAM_RD_I && SINGLE_CHIP_O && !RAM_EN_O
		|=> RAM_RDATA_O == 8'hff;
	endproperty
	a_ram_blocked: assert property (p_ram_blocked)
		else $error("blocked RAM read not 0xff");

	property p_exc_entry;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		EXC_ENTRY_I |=> SET_INT_MASK_O && SET_USER_MASK_O == !$past(s_r.ue);
	endproperty
	a_exc_entry: assert property (p_exc_entry)
		else $error("exception entry masks wrong");

	property p_mode3;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		s_r.mode_sync == MSC_MODE3
		|=> SPACE_16M_O && EXPANDED_O && !ROM_EN_O && MODE_VALID_O;
	endproperty
	a_mode3: assert property (p_mode3)
		else $error("mode 3 decoded wrongly");

	property p_reset_value;
		@(posedge CORE_CLK_I)
		!RST_B_I |=> msc_sys_value(s_r) == 8'h0b;
	endproperty
	a_reset_value: assert property (p_reset_value)
		else $error("control register reset value wrong");
endmodule // msc_top

// >>> design/msc_pkg.sv
// Constants, field layout and reset values of the mode and system control.
// Assumes one system clock, a synchronous active-low reset and static straps.
//
// Contract
// - Mode pins decode to modes 1,3,5,6,7; 000, 010, 100 unsupported.
// - Modes 1 and 3: on-chip ROM off, expanded operation.
// - Modes 5 and 6: expanded operation with on-chip ROM enabled.
// - Modes 1,5,7 use 1 Mbyte space; modes 3,6 use 16 Mbytes.
// - Mode 7 is single chip, all ports usable, 1 Mbyte space.
// - Mode readback register is eight bits and ignores writes.
// - Readback bits 7:6 read one, bits 5:3 read zero, unalterable.
// - Readback bits 2:0 show mode pins, sampled when read.
// - Standby select 0: sleep enters sleep; 1: software standby; resets 0.
// - Standby select stays one after standby exit until software clears it.
// - Wait field picks settling states 8192..131072 or 1024; resets 000.
// - User-flag enable 0 makes user flag a mask, 1 a user bit; resets 1.
// - NMI edge select 0 falling edge, 1 rising edge; resets 0.
// - System control bit 1 is reserved, unwritable, reads one.
// - RAM enable 1 enables on-chip RAM; set by reset, kept through standby.
// - Expanded modes with RAM disabled decode the RAM range externally.
// - Mode 7 with RAM disabled reads 0xff and drops writes.
// - Expanded modes start with an 8-bit external bus.
// - Exception entry sets mask bit; also user flag when user-flag enable 0.

package msc_pkg;
	// Register offsets (low 16 address bits)
	localparam logic [15:0] MSC_READBACK_OFS = 16'hfff1;
	localparam logic [15:0] MSC_SYS_CTRL_OFS = 16'hfff2;

	// Readback layout
	localparam logic [7:0] MSC_READBACK_FIXED = 8'hc0;
	localparam int MSC_PIN_FIELD_W = 3;

	// System control layout and reset value
	localparam int MSC_STANDBY_SELECT_BIT = 7;
	localparam int MSC_STS_HI = 6;
	localparam int MSC_STS_LO = 4;
	localparam int MSC_UE_BIT = 3;
	localparam int MSC_NONMASKABLE_EDGE_SELECT_BIT = 2;
	localparam int MSC_RSV_BIT = 1;
	localparam int MSC_ONCHIP_RAM_ENABLE_BIT = 0;
	localparam logic [7:0] MSC_SYS_CTRL_RST = 8'h0b;

	// Mode pin patterns
	localparam logic [2:0] MSC_MODE1 = 3'h1;
	localparam logic [2:0] MSC_MODE3 = 3'h3;
	localparam logic [2:0] MSC_MODE5 = 3'h5;
	localparam logic [2:0] MSC_MODE6 = 3'h6;
	localparam logic [2:0] MSC_MODE7 = 3'h7;

	// Oscillator settling waits, in states (system clock cycles)
	localparam int MSC_WAIT_SEL0 = 8192;
	localparam int MSC_WAIT_SEL1 = 16384;
	localparam int MSC_WAIT_SEL2 = 32768;
	localparam int MSC_WAIT_SEL3 = 65536;
	localparam int MSC_WAIT_SEL4 = 131072;
	localparam int MSC_WAIT_SEL5 = 1024;
	localparam int MSC_WAIT_W = 18;

	// On-chip RAM read value while blocked in single-chip mode
	localparam logic [7:0] MSC_RAM_BLOCKED_DATA = 8'hff;

	typedef enum logic [1:0] {
		MSC_PWR_RUN,
		MSC_PWR_SLEEP,
		MSC_PWR_STANDBY,
		MSC_PWR_SETTLE
	} msc_pwr_t;
endpackage

// >>> design/msc_settle_timer.sv
// Oscillator settling down-counter used on leaving software standby.
// Assumes start_i is a one-cycle pulse from the same clock domain.

module msc_settle_timer #(
	parameter int CNT_W = msc_pkg::MSC_WAIT_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Control
	input wire logic start_i,
	input wire logic [CNT_W-1:0] count_i,
	// Status
	output logic done_o
);
	import msc_pkg::*;

	typedef struct packed {
		logic busy;
		logic [CNT_W-1:0] cnt;
		logic done;
	} msc_tmr_t;

	msc_tmr_t s_r;
	msc_tmr_t s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		if (start_i)
		begin
			s_nxt.busy = 1'b1;
			s_nxt.cnt = count_i;
		end
		else if (s_r.busy)
		begin
			// Count the full programmed number of states before release
			if (s_r.cnt <= CNT_W'(1))
			begin
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
			end
			else
			begin
				s_nxt.cnt = s_r.cnt - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign done_o = s_r.done;
endmodule // msc_settle_timer

// >>> tb/msc_strap_model.sv
// Board strapping of the three mode pins.
// Assumes the bench changes strap_i only while the block is held in reset.
module msc_strap_model (
	// Chosen strap pattern
	input wire logic [2:0] strap_i,
	// Mode pins
	output logic mode_pin_high_o,
	output logic mode_pin_mid_o,
	output logic mode_pin_low_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Driven hard and never floated: straps are static while running
	assign {mode_pin_high_o, mode_pin_mid_o, mode_pin_low_o} = strap_i;
endmodule // msc_strap_model

// >>> tb/mode_select_system_control_bench.sv
// Self-checking bench for mode decode, readback and system control.
// Assumes shortened settling waits; straps move only under reset.
module mode_select_system_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import msc_pkg::*;
	localparam int W [6] = '{20, 24, 28, 32, 36, 8};
	logic clk, rst_b, wr, rd, nmi, rd_d, ram_rd_d;
	logic [5:0] pls;
	logic [15:0] addr;
	logic [7:0] wdata, rdata, ram_di, ram_do;
	logic [2:0] strap;
	logic pin_h, pin_m, pin_l, valid, expd, rom, s16, sc, bus8;
	logic slp_o, stby_o, settle_o, nmi_req, ue_o, set_i, set_u;
	logic ram_we, ram_en, ram_ext;
	logic [7:0] rq [$];
	logic [7:0] mq [$];
	int failures, num_checks;

	msc_strap_model i_msc_strap_model (.strap_i(strap),
		.mode_pin_high_o(pin_h), .mode_pin_mid_o(pin_m),
		.mode_pin_low_o(pin_l));

	msc_top #(.WAIT_SEL0(W[0]), .WAIT_SEL1(W[1]), .WAIT_SEL2(W[2]),
		.WAIT_SEL3(W[3]), .WAIT_SEL4(W[4]), .WAIT_SEL5(W[5])) i_msc_top (
		.CORE_CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr),
		.REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
		.REG_RDATA_O(rdata), .MODE_PIN_HIGH_I(pin_h),
		.MODE_PIN_MID_I(pin_m), .MODE_PIN_LOW_I(pin_l),
		.MODE_VALID_O(valid), .EXPANDED_O(expd), .ROM_EN_O(rom),
		.SPACE_16M_O(s16), .SINGLE_CHIP_O(sc), .BUS_8BIT_O(bus8),
		.SLEEP_I(pls[0]), .IRQ_I(pls[1]), .EXT_IRQ_I(pls[2]),
		.SLEEP_O(slp_o), .STANDBY_O(stby_o), .SETTLING_O(settle_o),
		.NMI_PIN_I(nmi), .EXC_ENTRY_I(pls[3]), .NMI_REQ_O(nmi_req),
		.USER_FLAG_ENABLE_O(ue_o), .SET_INT_MASK_O(set_i),
		.SET_USER_MASK_O(set_u), .RAM_RD_I(pls[4]), .RAM_WR_I(pls[5]),
		.RAM_RDATA_I(ram_di), .RAM_RDATA_O(ram_do),
		.RAM_WR_EN_O(ram_we), .RAM_EN_O(ram_en), .RAM_EXTERNAL_O(ram_ext));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] s);
		num_checks++;
		if (s !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// For a read, d is the expected answer, noted for the monitor
	task automatic acc(input logic w, input logic [15:0] a,
		input logic [7:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		if (!w)
			rq.push_back(d);
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	// Leaves time 1 ns past the edge on which the output answers
	task automatic pulse(input int k);
		@(posedge clk);
		pls[k] <= 1'b1;
		@(posedge clk);
		pls <= '0;
		#1;
	endtask

	task automatic reset_to(input logic [2:0] p);
		@(posedge clk);
		rst_b <= 1'b0;
		strap <= p;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
	endtask

	task automatic ram_chk(input logic blk);
		logic [7:0] d;
		d = 8'($urandom);
		ram_di <= d;
		mq.push_back(blk ? MSC_RAM_BLOCKED_DATA : d);
		pulse(4);
		pulse(5);
		chk("ram write enable", {7'h0, ram_we}, {7'h0, !blk});
	endtask

	task automatic nmi_chk(input logic v, input int e);
		int n;
		@(posedge clk);
		nmi <= v;
		n = 0;
		repeat (8)
		begin
			@(posedge clk);
			#1;
			n += int'(nmi_req);
		end
		chk("nmi request", 8'(n), 8'(e));
	endtask

	// Answers are compared in the cycle after their strobe
	always @(posedge clk)
	begin
		if (rd_d)
			chk("reg read", rq.size() > 0 ? rq.pop_front() : 8'hxx,
				rdata);
		if (ram_rd_d)
			chk("ram read", mq.size() > 0 ? mq.pop_front() : 8'hxx,
				ram_do);
		rd_d <= rd;
		ram_rd_d <= pls[4];
	end

	initial
	begin
		logic [7:0] d;
		logic [2:0] p3;
		logic ex;
		int n;
		{wr, rd, rst_b} = '0;
		pls = '0;
		nmi = 1'b1;
		addr = '0;
		wdata = '0;
		ram_di = '0;
		strap = MSC_MODE7;
		failures = 0;
		num_checks = 0;
		void'($urandom(32'hcea2));
		reset_to(MSC_MODE7);
		chk("user flag enable", {7'h0, ue_o}, 8'h01);
		chk("ram enable", {7'h0, ram_en}, 8'h01);
		acc(0, MSC_SYS_CTRL_OFS, MSC_SYS_CTRL_RST);
		acc(1, 16'hfff3, 8'h55);
		acc(0, 16'hfff3, 8'h00);
		for (int p = 0; p < 8; p++)
		begin
			p3 = 3'(p);
			reset_to(p3);
			ex = p3 inside {MSC_MODE1, MSC_MODE3, MSC_MODE5, MSC_MODE6};
			d = {2'h0, p3 inside {MSC_MODE1, MSC_MODE3, MSC_MODE5,
				MSC_MODE6, MSC_MODE7}, ex,
				p3 inside {MSC_MODE5, MSC_MODE6, MSC_MODE7},
				p3 inside {MSC_MODE3, MSC_MODE6}, p3 == MSC_MODE7, ex};
			chk("decode", {2'h0, valid, expd, rom, s16, sc, bus8},
				d);
			acc(1, MSC_READBACK_OFS, 8'h00);
			acc(0, MSC_READBACK_OFS,
				MSC_READBACK_FIXED | {5'h0, p3});
			ram_chk(1'b0);
			acc(1, MSC_SYS_CTRL_OFS, 8'h08);
			repeat (3) @(posedge clk);
			#1;
			chk("ram external", {7'h0, ram_ext}, {7'h0, ex});
			ram_chk(p3 == MSC_MODE7);
			acc(0, MSC_SYS_CTRL_OFS, 8'h0a);
		end
		for (int i = 0; i < 4; i++)
		begin
			d = 8'($urandom);
			if (d[6:5] == 2'b11)
				d[6] = 1'b0;
			acc(1, MSC_SYS_CTRL_OFS, d);
			acc(0, MSC_SYS_CTRL_OFS, d | 8'h02);
			pulse(3);
			chk("mask set", {6'h0, set_i, set_u},
				{6'h0, 1'b1, !d[3]});
			chk("user flag", {7'h0, ue_o}, {7'h0, d[3]});
		end
		acc(1, MSC_SYS_CTRL_OFS, 8'h0b);
		nmi_chk(1'b0, 1);
		nmi_chk(1'b1, 0);
		acc(1, MSC_SYS_CTRL_OFS, 8'h0f);
		nmi_chk(1'b0, 0);
		nmi_chk(1'b1, 1);
		acc(1, MSC_SYS_CTRL_OFS, 8'h0b);
		pulse(0);
		chk("sleep", {7'h0, slp_o}, 8'h01);
		pulse(1);
		chk("sleep", {7'h0, slp_o}, 8'h00);
		for (int k = 0; k < 6; k++)
		begin
			d = 8'h8b | 8'(k << 4);
			acc(1, MSC_SYS_CTRL_OFS, d);
			pulse(0);
			chk("standby", {7'h0, stby_o}, 8'h01);
			pulse(2);
			n = 0;
			while (settle_o === 1'b1 && n < 200)
			begin
				@(posedge clk);
				#1;
				n++;
			end
			if (n >= 200)
			begin
				failures++;
				give_verdict();
			end
			chk("settle", 8'(n >= W[k] - 1 && n <= W[k] + 4), 8'h01);
			chk("ram enable", {7'h0, ram_en}, 8'h01);
			acc(0, MSC_SYS_CTRL_OFS, d);
		end
		repeat (3) @(posedge clk);
		give_verdict();
	end
endmodule // mode_select_system_control_bench
